// [core/bpe_consts.svh]
`ifndef BPE_CONSTS_SVH
`define BPE_CONSTS_SVH

// Clock and instruction cycle timing
`define BPE_CLK_PERIOD_NS  50
`define BPE_TCY_NS         200
`define BPE_TCY_CLKS       (`BPE_TCY_NS / `BPE_CLK_PERIOD_NS)

// Instruction word layout
`define BPE_IW_WIDTH       14
`define BPE_ADDR_WIDTH     7
`define BPE_DATA_WIDTH     8
`define BPE_FILE_DEPTH     128
`define BPE_DEST_BIT       7

// Opcode patterns, upper six bits of the word
`define BPE_OPC_DEC_SKIP   6'h0B
`define BPE_OPC_INC_SKIP   6'h0F
`define BPE_OPC_OR_REG     6'h04
`define BPE_OPC_STORE      6'h00
`define BPE_OPC_LOAD_IMM   6'h30
`define BPE_OPC_OR_IMM     6'h38

// Reset values and byte constants
`define BPE_ACC_RESET      8'h00
`define BPE_ZERO_RESET     1'h0
`define BPE_BYTE_ZERO      8'h00
`define BPE_BYTE_ONE       8'h01

`endif

// [core/bpe_exec.sv]
`timescale 1ns/100ps
`include "bpe_consts.svh"

// Functional notes
// [RQ1] Decrement, write per d, skip when zero
// [RQ2] Increment, write per d, skip on wrap
// [RQ3] Skip ops keep flags; nonzero runs next
// [RQ4] OR accumulator with register, d picks target
// [RQ5] OR immediate into accumulator, update zero
// [RQ6] Load immediate, flags kept, dont-cares zero
// [RQ7] Store accumulator to seven-bit address
// [RQ8] Zero flag set on zero, else cleared
module bpe_exec
  import bpe_pkg::*;
#(
  parameter int TCY_CLKS = `BPE_TCY_CLKS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Instruction stream
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  output logic             instr_ready,
  // Core state
  output logic [7:0]       accum_q,
  output logic             zero_flag_q,
  output logic             skip_pending_q,
  output logic             idle_slot_q,
  output logic             unhandled_q,
  // File register observation
  input  wire logic [6:0]  obs_addr,
  output logic [7:0]       obs_data
);

  // Refuse an instruction cycle shorter than one clock
  if (TCY_CLKS < 1) begin : g_tcy_chk
    $error("bpe_exec: instruction cycle must span at least one clock");
  end

  localparam int CNT_W = (TCY_CLKS > 1) ? $clog2(TCY_CLKS) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TCY_CLKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [CNT_W-1:0] tcy_cnt_reg;
  logic             tcy_en;
  logic             take;
  logic             squash;
  bpe_op_e          op;
  logic             dest_file;
  logic [6:0]       f_addr;
  bpe_byte_t        imm;
  bpe_byte_t        f_data;
  bpe_byte_t        result;
  logic             wr_en;
  logic             acc_load;
  logic             zero_upd;
  logic             skip_set;
  bpe_byte_t        accum_reg;
  logic             zero_flag_reg;
  logic             skip_pending_reg;
  logic             idle_slot_reg;
  logic             unhandled_reg;

  // Instruction cycle enable divider
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tcy_cnt_reg <= CNT_ZERO;
    end else if (tcy_cnt_reg == CNT_LAST) begin
      tcy_cnt_reg <= CNT_ZERO;
    end else begin
      tcy_cnt_reg <= tcy_cnt_reg + 1'b1;
    end
  end

  assign tcy_en      = (tcy_cnt_reg == CNT_LAST);
  assign instr_ready = tcy_en;
  assign take        = tcy_en && instr_valid;
  assign squash      = take && skip_pending_reg;

  // Field extraction
  assign op        = bpe_decode(instr_word);
  assign dest_file = instr_word[`BPE_DEST_BIT];
  assign f_addr    = instr_word[6:0];
  assign imm       = instr_word[7:0];

  bpe_file_regs u_file_regs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_addr  (f_addr),
    .rd_data  (f_data),
    .wr_en    (wr_en),
    .wr_addr  (f_addr),
    .wr_data  (result),
    .obs_addr (obs_addr),
    .obs_data (obs_data)
  );

  // Result and destination selection
  always_comb begin
    result   = accum_reg;
    wr_en    = 1'b0;
    acc_load = 1'b0;
    zero_upd = 1'b0;
    skip_set = 1'b0;
    if (take && !squash) begin
      unique case (op)
        BPE_OP_DEC_SKIP: begin
          result   = f_data - `BPE_BYTE_ONE; // RQ1
          wr_en    = dest_file; // RQ1
          acc_load = !dest_file; // RQ1
          skip_set = bpe_is_zero(result); // RQ1 RQ3
        end
        BPE_OP_INC_SKIP: begin
          result   = f_data + `BPE_BYTE_ONE; // RQ2
          wr_en    = dest_file; // RQ2
          acc_load = !dest_file; // RQ2
          skip_set = bpe_is_zero(result); // RQ2 RQ3
        end
        BPE_OP_OR_REG: begin
          result   = accum_reg | f_data; // RQ4
          wr_en    = dest_file; // RQ4
          acc_load = !dest_file; // RQ4
          zero_upd = 1'b1; // RQ4
        end
        BPE_OP_OR_IMM: begin
          result   = accum_reg | imm; // RQ5
          acc_load = 1'b1; // RQ5
          zero_upd = 1'b1; // RQ5
        end
        BPE_OP_LOAD_IMM: begin
          result   = imm; // RQ6
          acc_load = 1'b1; // RQ6
        end
        BPE_OP_STORE: begin
          result = accum_reg; // RQ7
          wr_en  = 1'b1; // RQ7
        end
        BPE_OP_IDLE, BPE_OP_OTHER: begin
          result = accum_reg;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accum_reg <= `BPE_ACC_RESET;
    end else if (acc_load) begin
      accum_reg <= result;
    end
  end

  // Zero flag, touched only by OR operations
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zero_flag_reg <= `BPE_ZERO_RESET;
    end else if (zero_upd) begin
      zero_flag_reg <= bpe_is_zero(result); // RQ8
    end
  end

  // Skip pending until the next instruction is turned into an idle slot
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skip_pending_reg <= 1'b0;
    end else if (skip_set) begin
      skip_pending_reg <= 1'b1; // RQ1 RQ2
    end else if (squash) begin
      skip_pending_reg <= 1'b0;
    end
  end

  // Idle slot and unhandled markers, one clock each
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_slot_reg <= 1'b0;
      unhandled_reg <= 1'b0;
    end else begin
      idle_slot_reg <= squash || (take && op == BPE_OP_IDLE);
      unhandled_reg <= take && !squash && op == BPE_OP_OTHER;
    end
  end

  assign accum_q        = accum_reg;
  assign zero_flag_q    = zero_flag_reg;
  assign skip_pending_q = skip_pending_reg;
  assign idle_slot_q    = idle_slot_reg;
  assign unhandled_q    = unhandled_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic live;
  assign live = take && !skip_pending_reg;

  dec_to_acc_a: assert property (live && op == BPE_OP_DEC_SKIP && !dest_file // RQ1
    |=> accum_q == $past(f_data) - `BPE_BYTE_ONE)
    else $error("decrement result wrong in accumulator");
  dec_skip_a: assert property (live && op == BPE_OP_DEC_SKIP && f_data == `BPE_BYTE_ONE // RQ1
    |=> skip_pending_q)
    else $error("decrement to zero did not skip");
  squash_idle_a: assert property (squash // RQ1 RQ2
    |=> idle_slot_q && !skip_pending_q && $stable(accum_q) && $stable(zero_flag_q))
    else $error("skipped instruction was not an idle slot");
  inc_to_file_a: assert property (live && op == BPE_OP_INC_SKIP && dest_file // RQ2
    |=> u_file_regs.mem_reg[$past(f_addr)] == $past(f_data) + `BPE_BYTE_ONE)
    else $error("increment result wrong in file");
  inc_skip_a: assert property (live && op == BPE_OP_INC_SKIP && f_data == 8'hFF // RQ2
    |=> skip_pending_q)
    else $error("increment wrap did not skip");
  skip_flags_a: assert property (live && (op == BPE_OP_DEC_SKIP || op == BPE_OP_INC_SKIP) // RQ3
    |=> $stable(zero_flag_q))
    else $error("skip instruction changed zero flag");
  no_skip_a: assert property (live && op == BPE_OP_INC_SKIP && f_data != 8'hFF // RQ3
    |=> !skip_pending_q)
    else $error("nonzero result caused a skip");
  or_reg_a: assert property (live && op == BPE_OP_OR_REG && !dest_file // RQ4
    |=> accum_q == ($past(accum_q) | $past(f_data)))
    else $error("register OR wrong");
  or_file_keep_a: assert property (live && op == BPE_OP_OR_REG && dest_file // RQ4
    |=> $stable(accum_q))
    else $error("register OR to file touched accumulator");
  or_imm_a: assert property (live && op == BPE_OP_OR_IMM // RQ5 RQ8
    |=> accum_q == ($past(accum_q) | $past(imm)) && zero_flag_q == (accum_q == 8'h00))
    else $error("immediate OR wrong");
  load_imm_a: assert property (live && op == BPE_OP_LOAD_IMM // RQ6
    |=> accum_q == $past(imm) && $stable(zero_flag_q))
    else $error("load immediate wrong");
  store_acc_a: assert property (live && op == BPE_OP_STORE // RQ7
    |-> wr_en && result == accum_q ##1 $stable(zero_flag_q))
    else $error("store accumulator wrong");
  zero_flag_a: assert property (zero_upd |=> zero_flag_q == ($past(result) == 8'h00)) // RQ8
    else $error("zero flag mismatch");

  dec_skip_c: cover property (skip_set && op == BPE_OP_DEC_SKIP ##[1:20] squash);
  inc_wrap_c: cover property (skip_set && op == BPE_OP_INC_SKIP);
  or_zero_c:  cover property (zero_upd && bpe_is_zero(result));
  store_c:    cover property (live && op == BPE_OP_STORE);

endmodule

// [core/bpe_file_regs.sv]
`timescale 1ns/100ps
`include "bpe_consts.svh"

module bpe_file_regs
  import bpe_pkg::*;
#(
  parameter int ADDR_W = `BPE_ADDR_WIDTH,
  parameter int DEPTH  = `BPE_FILE_DEPTH
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Execution read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data,
  // Execution write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  // Observation port
  input  wire logic [ADDR_W-1:0] obs_addr,
  output logic      [7:0]        obs_data
);

  // Refuse a depth that the address cannot reach
  if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_depth_chk
    $error("bpe_file_regs: depth does not fit the address width");
  end

  bpe_byte_t mem_reg [DEPTH];

  // File register array, cleared at reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= `BPE_BYTE_ZERO;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Asynchronous reads
  assign rd_data  = mem_reg[rd_addr];
  assign obs_data = mem_reg[obs_addr];

endmodule

// [core/bpe_pkg.sv]
`include "bpe_consts.svh"

package bpe_pkg;

  typedef enum logic [2:0] {
    BPE_OP_OTHER,
    BPE_OP_IDLE,
    BPE_OP_DEC_SKIP,
    BPE_OP_INC_SKIP,
    BPE_OP_OR_REG,
    BPE_OP_OR_IMM,
    BPE_OP_LOAD_IMM,
    BPE_OP_STORE
  } bpe_op_e;

  typedef logic [`BPE_DATA_WIDTH-1:0] bpe_byte_t;

  // Classify an instruction word into one of the handled operations
  function automatic bpe_op_e bpe_decode(input logic [`BPE_IW_WIDTH-1:0] iw);
    bpe_op_e op;
    op = BPE_OP_OTHER;
    unique case (iw[13:8])
      `BPE_OPC_DEC_SKIP: op = BPE_OP_DEC_SKIP;
      `BPE_OPC_INC_SKIP: op = BPE_OP_INC_SKIP;
      `BPE_OPC_OR_REG:   op = BPE_OP_OR_REG;
      `BPE_OPC_STORE: begin
        if (iw[`BPE_DEST_BIT]) begin
          op = BPE_OP_STORE;
        end else if (iw[6:0] == 7'h00) begin
          op = BPE_OP_IDLE;
        end
      end
      `BPE_OPC_LOAD_IMM: op = BPE_OP_LOAD_IMM;
      `BPE_OPC_OR_IMM:   op = BPE_OP_OR_IMM;
      default:           op = BPE_OP_OTHER;
    endcase
    return op;
  endfunction

  // Zero test shared by every flag update
  function automatic logic bpe_is_zero(input bpe_byte_t v);
    return (v == `BPE_BYTE_ZERO);
  endfunction

endpackage

// [verification/bpe_exec_tb.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
    end \
  end

module bpe_exec_tb;
  typedef struct {logic [7:0] acc; logic z; logic skip; logic idle; logic unh;
                  logic [7:0] file;} bpe_note_s;

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic        instr_ready;
  logic [7:0]  accum_q;
  logic        zero_flag_q;
  logic        skip_pending_q;
  logic        idle_slot_q;
  logic        unhandled_q;
  logic [6:0]  obs_addr = 7'h00;
  logic [7:0]  obs_data;
  int          fails = 0;
  int          total_checks = 0;
  int          ready_gap = -1;
  logic        take_seen = 1'b0;
  bpe_note_s   notes[$];
  bpe_note_s   mon_n;
  logic [7:0]  m_acc;
  logic        m_z;
  logic        m_skip;
  logic [7:0]  m_mem[128];
  logic [13:0] dir_words[20] = '{14'h3005, 14'h0080, 14'h00FF, 14'h3001, 14'h0081,
    14'h0B81, 14'h30AA, 14'h3000, 14'h3800, 14'h30FF, 14'h0082, 14'h0F02, 14'h0B81,
    14'h0402, 14'h0000, 14'h3100, 14'h0001, 14'h2000, 14'h0F83, 14'h0483};

  bpe_exec u_bpe_exec (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .instr_valid    (instr_valid),
    .instr_word     (instr_word),
    .instr_ready    (instr_ready),
    .accum_q        (accum_q),
    .zero_flag_q    (zero_flag_q),
    .skip_pending_q (skip_pending_q),
    .idle_slot_q    (idle_slot_q),
    .unhandled_q    (unhandled_q),
    .obs_addr       (obs_addr),
    .obs_data       (obs_data)
  );

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset pulse, model cleared, reset state checked
  task automatic do_reset();
    @(negedge clk_sys);
    rst <= 1'b1;
    instr_valid <= 1'b0;
    obs_addr <= 7'($urandom_range(0, 127));
    repeat (5) @(negedge clk_sys);
    `CHK("accum", 8'h00, accum_q)
    `CHK("zero", 1'b0, zero_flag_q)
    `CHK("skip", 1'b0, skip_pending_q)
    `CHK("file", 8'h00, obs_data)
    rst <= 1'b0;
    m_acc = 8'h00;
    m_z = 1'b0;
    m_skip = 1'b0;
    foreach (m_mem[j]) m_mem[j] = 8'h00;
  endtask

  // Present one word, held until taken; note the expected outcome
  task automatic issue(input logic [13:0] w);
    bpe_note_s n;
    logic [7:0] r;
    logic [6:0] f;
    int tries;
    f = w[6:0];
    tries = 0;
    n.idle = 1'b0;
    n.unh = 1'b0;
    @(negedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    obs_addr <= f;
    while (instr_ready !== 1'b1 && tries < 8) begin
      @(negedge clk_sys);
      tries++;
    end
    if (tries >= 8) begin
      fails++;
      $display("unexpected ready: expected 1 seen 0");
    end
    if (m_skip) begin
      m_skip = 1'b0;
      n.idle = 1'b1;
    end else begin
      case (w[13:8])
        6'h0B, 6'h0F: begin
          r = (w[13:8] == 6'h0B) ? m_mem[f] - 8'h01 : m_mem[f] + 8'h01;
          if (w[7]) m_mem[f] = r; else m_acc = r;
          m_skip = (r == 8'h00);
        end
        6'h04: begin
          r = m_acc | m_mem[f];
          m_z = (r == 8'h00);
          if (w[7]) m_mem[f] = r; else m_acc = r;
        end
        6'h38: begin
          m_acc = m_acc | w[7:0];
          m_z = (m_acc == 8'h00);
        end
        6'h30: m_acc = w[7:0];
        6'h00: begin
          if (w[7]) m_mem[f] = m_acc;
          else if (f == 7'h00) n.idle = 1'b1;
          else n.unh = 1'b1;
        end
        default: n.unh = 1'b1;
      endcase
    end
    n.acc = m_acc;
    n.z = m_z;
    n.skip = m_skip;
    n.file = m_mem[f];
    notes.push_back(n);
    @(negedge clk_sys);
    instr_valid <= 1'b0;
  endtask

  // Marks clocks that took an instruction
  always @(posedge clk_sys) take_seen <= !rst && instr_ready && instr_valid;

  // Result watcher: oldest note against outputs after each take
  always @(negedge clk_sys) begin
    if (take_seen) begin
      if (notes.size() == 0) begin
        fails++;
        $display("unexpected note: expected 1 seen 0");
      end else begin
        mon_n = notes.pop_front();
        `CHK("accum", mon_n.acc, accum_q)
        `CHK("zero", mon_n.z, zero_flag_q)
        `CHK("skip", mon_n.skip, skip_pending_q)
        `CHK("idle", mon_n.idle, idle_slot_q)
        `CHK("unhandled", mon_n.unh, unhandled_q)
        `CHK("file", mon_n.file, obs_data)
      end
    end else if (!rst) begin
      `CHK("idle quiet", 1'b0, idle_slot_q)
      `CHK("unhandled quiet", 1'b0, unhandled_q)
    end
    // Ready stands one clock in every four
    if (rst) begin
      ready_gap = -1;
    end else if (instr_ready) begin
      if (ready_gap >= 0) `CHK("ready gap", 3, ready_gap)
      ready_gap = 0;
    end else if (ready_gap >= 0) begin
      ready_gap++;
    end
  end

  // Hang guard
  initial begin
    #2000000;
    fails++;
    give_verdict();
  end

  // Directed sequence, then random mix with a reset midway
  initial begin
    logic [13:0] w;
    logic [7:0]  k;
    logic [6:0]  f;
    void'($urandom(32'h89CB27D5));
    do_reset();
    foreach (dir_words[i]) issue(dir_words[i]);
    for (int i = 0; i < 300; i++) begin
      if (i == 150) do_reset();
      k = 8'($urandom_range(0, 255));
      f = ($urandom_range(0, 3) == 0) ? 7'h7F : 7'($urandom_range(0, 3));
      case ($urandom_range(0, 6))
        0: w = {6'h0B, k[0], f};
        1: w = {6'h0F, k[0], f};
        2: w = {6'h04, k[0], f};
        3: w = {6'h38, k};
        4: w = {6'h30, k};
        5: w = {7'h01, f};
        default: w = 14'($urandom);
      endcase
      issue(w);
    end
    repeat (4) @(negedge clk_sys);
    `CHK("notes left", 0, notes.size())
    give_verdict();
  end
endmodule
